// >>> motion_sequence_runner.sv
`timescale 1ns/1ps
`include "seq_defines.svh"

module motion_sequence_runner
  import seq_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [5:0] firstEntryNumber,
  input wire logic [5:0] lastEntryNumber,
  input wire logic tableWrite,
  input wire logic [4:0] tableWriteAddr,
  input wire entry_s tableWriteData,
  input wire logic axisEnabled,
  input wire logic otherJobStart,
  input wire logic motionDone,
  input wire logic motionFault,
  output seq_status_s status,
  output motion_cmd_s motionCmd,
  output logic abortOtherJobs
);
  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_MOTION, S_WAIT} state_e;

  typedef struct packed {
    state_e state;
    logic startPrev;
    logic [5:0] index;
    logic [5:0] last;
    logic lastWasVel;
    logic tookOver;
    logic [31:0] waitCount;
    seq_status_s st;
    motion_cmd_s cmd;
    logic abortOut;
  } state_s;

  entry_s table_q [`SEQ_ENTRIES];
  state_s s_q, s_d;
  entry_s cur;

  function automatic logic isMotion(input cmd_kind_e k);
    isMotion = (k == CMD_REL) || (k == CMD_ABS) || (k == CMD_VEL) || (k == CMD_HALT);
  endfunction

  always_ff @(posedge clock) begin
    if (tableWrite) begin
      table_q[tableWriteAddr] <= tableWriteData;
    end
  end

  assign cur = table_q[s_q.index[4:0] - 5'h01];

  always_comb begin
    s_d = s_q;
    s_d.startPrev = start;
    s_d.cmd.valid = 1'b0;
    s_d.abortOut = 1'b0;
    if (start && !s_q.startPrev) begin
      s_d.st = '0;
      s_d.tookOver = 1'b0;
      s_d.lastWasVel = 1'b0;
      // restart drops old run; others aborted at first motion only
      if (firstEntryNumber == 6'h00 || firstEntryNumber > lastEntryNumber
          || lastEntryNumber > `SEQ_LAST_DEFAULT) begin
        s_d.st.error = 1'b1;
        s_d.st.faultId = `SEQ_ERR_RANGE;
        s_d.st.faultInfo = {10'h000, firstEntryNumber};
        s_d.state = S_IDLE;
      end else if (!axisEnabled) begin
        s_d.st.error = 1'b1;
        s_d.st.faultId = `SEQ_ERR_AXIS;
        s_d.state = S_IDLE;
      end else begin
        s_d.st.busy = 1'b1;
        s_d.index = firstEntryNumber;
        s_d.last = lastEntryNumber;
        s_d.state = S_FETCH;
      end
    end else if (s_q.st.busy && otherJobStart) begin
      s_d.st.aborted = 1'b1;
      s_d.st.busy = 1'b0;
      s_d.state = S_IDLE;
    end else if (s_q.st.busy && motionFault) begin
      s_d.st.error = 1'b1;
      s_d.st.busy = 1'b0;
      s_d.st.faultId = `SEQ_ERR_MOTION;
      s_d.st.faultInfo = {10'h000, s_q.st.step};
      s_d.state = S_IDLE;
    end else begin
      case (s_q.state)
        S_IDLE: begin
        end
        S_FETCH: begin
          if (s_q.index > s_q.last) begin
            s_d.st.done = 1'b1;
            s_d.st.busy = 1'b0;
            s_d.state = S_IDLE;
          end else begin
            s_d.index = s_q.index + 6'h01;
            case (cur.kind)
              CMD_EMPTY, CMD_SEP: begin
              end
              CMD_HALT, CMD_REL, CMD_ABS, CMD_VEL: begin
                s_d.st.step = s_q.index;
                s_d.st.code = cur.code;
                if (cur.kind != CMD_HALT || s_q.lastWasVel) begin
                  s_d.cmd.valid = 1'b1;
                  s_d.cmd.kind = cur.kind;
                  s_d.cmd.value = cur.value;
                  s_d.cmd.speed = cur.speed;
                  s_d.lastWasVel = (cur.kind == CMD_VEL);
                  if (!s_q.tookOver) begin
                    s_d.abortOut = 1'b1;
                    s_d.tookOver = 1'b1;
                  end
                  if (cur.kind != CMD_VEL) begin
                    s_d.state = S_MOTION;
                  end
                end
              end
              CMD_WAIT: begin
                s_d.st.step = s_q.index;
                s_d.st.code = cur.code;
                s_d.waitCount = cur.value;
                s_d.state = S_WAIT;
              end
              default: begin
                s_d.st.error = 1'b1;
                s_d.st.busy = 1'b0;
                s_d.st.faultId = `SEQ_ERR_KIND;
                s_d.st.faultInfo = {10'h000, s_q.index};
                s_d.state = S_IDLE;
              end
            endcase
          end
        end
        S_MOTION: begin
          if (motionDone) begin
            s_d.state = S_FETCH;
          end
        end
        S_WAIT: begin
          // motion already commanded keeps running
          if (s_q.waitCount == 32'h0000_0000) begin
            s_d.state = S_FETCH;
          end else begin
            s_d.waitCount = s_q.waitCount - 32'h0000_0001;
          end
        end
        default: begin
          s_d.state = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign status = s_q.st;
  assign motionCmd = s_q.cmd;
  assign abortOtherJobs = s_q.abortOut;

  property p_done_clears_busy;
    @(posedge clock) disable iff (!reset_n)
      $rose(status.done) |-> !status.busy && $past(status.busy);
  endproperty
  a_done_clears_busy: assert property (p_done_clears_busy)
    else $error("done rose without busy ending");

  property p_abort_on_other;
    @(posedge clock) disable iff (!reset_n)
      (status.busy && otherJobStart && !(start && !s_q.startPrev))
        |=> status.aborted && !status.busy;
  endproperty
  a_abort_on_other: assert property (p_abort_on_other)
    else $error("other job did not abort table");

  property p_busy_needs_edge;
    @(posedge clock) disable iff (!reset_n)
      $rose(status.busy) |-> $past(start) && !$past(s_q.startPrev);
  endproperty
  a_busy_needs_edge: assert property (p_busy_needs_edge)
    else $error("busy rose without start edge");

  property p_error_has_id;
    @(posedge clock) disable iff (!reset_n)
      status.error |-> status.faultId != `SEQ_WORD_RESET && !status.busy;
  endproperty
  a_error_has_id: assert property (p_error_has_id)
    else $error("error without identifier");

  property p_done_not_error;
    @(posedge clock) disable iff (!reset_n)
      status.done |-> !status.error && !status.aborted;
  endproperty
  a_done_not_error: assert property (p_done_not_error)
    else $error("done with fault");

  property p_cmd_busy;
    @(posedge clock) disable iff (!reset_n)
      motionCmd.valid |-> status.busy && status.step != `SEQ_STEP_RESET;
  endproperty
  a_cmd_busy: assert property (p_cmd_busy)
    else $error("command issued while idle");

  property p_halt_after_vel;
    @(posedge clock) disable iff (!reset_n)
      (motionCmd.valid && motionCmd.kind == CMD_HALT) |-> $past(s_q.lastWasVel);
  endproperty
  a_halt_after_vel: assert property (p_halt_after_vel)
    else $error("halt issued without velocity before");

  property p_abort_once;
    @(posedge clock) disable iff (!reset_n)
      (abortOtherJobs && motionCmd.valid) |=> !(abortOtherJobs && motionCmd.valid);
  endproperty
  a_abort_once: assert property (p_abort_once)
    else $error("abort repeated on consecutive motion");

  property p_abort_with_cmd;
    @(posedge clock) disable iff (!reset_n)
      abortOtherJobs |-> motionCmd.valid && isMotion(motionCmd.kind);
  endproperty
  a_abort_with_cmd: assert property (p_abort_with_cmd)
    else $error("abort pulse without motion launch");

  property p_cmd_content;
    @(posedge clock) disable iff (!reset_n)
      motionCmd.valid |-> isMotion(motionCmd.kind) && motionCmd.kind == $past(cur.kind)
        && motionCmd.value == $past(cur.value) && motionCmd.speed == $past(cur.speed);
  endproperty
  a_cmd_content: assert property (p_cmd_content)
    else $error("command does not carry entry fields");

  property p_step_advance;
    @(posedge clock) disable iff (!reset_n)
      motionCmd.valid |-> status.step == $past(s_q.index) && status.code == $past(cur.code);
  endproperty
  a_step_advance: assert property (p_step_advance)
    else $error("step or code not of launched entry");

  property p_start_answer;
    @(posedge clock) disable iff (!reset_n)
      (start && !s_q.startPrev) |=> status.busy || status.error;
  endproperty
  a_start_answer: assert property (p_start_answer)
    else $error("start edge gave neither busy nor error");

  property p_empty_skip;
    @(posedge clock) disable iff (!reset_n)
      (s_q.state == S_FETCH && s_q.index <= s_q.last && !(start && !s_q.startPrev)
        && (cur.kind == CMD_EMPTY || cur.kind == CMD_SEP))
        |=> !motionCmd.valid && $stable(status.step);
  endproperty
  a_empty_skip: assert property (p_empty_skip)
    else $error("empty or separator entry acted");

  property p_vel_continues;
    @(posedge clock) disable iff (!reset_n)
      (motionCmd.valid && motionCmd.kind == CMD_VEL) |-> s_q.state == S_FETCH;
  endproperty
  a_vel_continues: assert property (p_vel_continues)
    else $error("velocity entry waited for completion");

  property p_wait_exit;
    @(posedge clock) disable iff (!reset_n)
      (s_q.state == S_WAIT && s_q.waitCount == 32'h0000_0000 && !otherJobStart
        && !motionFault && !(start && !s_q.startPrev)) |=> s_q.state == S_FETCH;
  endproperty
  a_wait_exit: assert property (p_wait_exit)
    else $error("wait did not end when period expired");

  property p_done_after_last;
    @(posedge clock) disable iff (!reset_n)
      $rose(status.done) |-> $past(s_q.index) == $past(s_q.last) + 6'h01;
  endproperty
  a_done_after_last: assert property (p_done_after_last)
    else $error("done before last entry");

  property p_fault_info;
    @(posedge clock) disable iff (!reset_n)
      (status.busy && motionFault && !otherJobStart && !(start && !s_q.startPrev))
        |=> status.error && status.faultInfo == {10'h000, $past(status.step)};
  endproperty
  a_fault_info: assert property (p_fault_info)
    else $error("motion fault not reported with step");
endmodule

// >>> seq_defines.svh
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH
`define SEQ_ENTRIES 32
`define SEQ_FIRST_DEFAULT 6'h01
`define SEQ_LAST_DEFAULT 6'h20
`define SEQ_WORD_RESET 16'h0000
`define SEQ_STEP_RESET 6'h00
`define SEQ_ERR_RANGE 16'h8001
`define SEQ_ERR_AXIS 16'h8002
`define SEQ_ERR_MOTION 16'h8003
`define SEQ_ERR_KIND 16'h8004
`endif

// >>> seq_pkg.sv
package seq_pkg;
  typedef enum logic [2:0] {
    CMD_EMPTY, CMD_HALT, CMD_REL, CMD_ABS, CMD_VEL, CMD_WAIT, CMD_SEP, CMD_BAD
  } cmd_kind_e;

  typedef struct packed {
    cmd_kind_e kind;
    logic [15:0] code;
    logic [31:0] value;
    logic [31:0] speed;
  } entry_s;

  typedef struct packed {
    logic valid;
    cmd_kind_e kind;
    logic [31:0] value;
    logic [31:0] speed;
  } motion_cmd_s;

  typedef struct packed {
    logic done;
    logic busy;
    logic aborted;
    logic error;
    logic [15:0] faultId;
    logic [15:0] faultInfo;
    logic [5:0] step;
    logic [15:0] code;
  } seq_status_s;
endpackage

// >>> axis_model.sv
`timescale 1ns/1ps
module axis_model
  import seq_pkg::*;
(
  input wire logic clock,
  input wire motion_cmd_s motionCmd,
  input wire logic stall,
  input wire logic failMove,
  output logic motionDone,
  output logic motionFault
);
  int pend = 0;
  initial begin
    motionDone = 1'b0;
    motionFault = 1'b0;
  end
  // rel, abs and halt moves end a few cycles after issue
  always @(posedge clock) begin
    motionDone <= 1'b0;
    motionFault <= 1'b0;
    if (motionCmd.valid && motionCmd.kind inside {CMD_REL, CMD_ABS, CMD_HALT}) begin
      pend <= 4;
    end else if (pend == 1 && !stall) begin
      motionDone <= !failMove;
      motionFault <= failMove;
      pend <= 0;
    end else if (pend > 1) begin
      pend <= pend - 1;
    end
  end
endmodule

// >>> motion_sequence_runner_tb.sv
`timescale 1ns/1ps
`include "seq_defines.svh"
module motion_sequence_runner_tb;
  import seq_pkg::*;
  logic clock, reset_n, start, tableWrite, axisEnabled, otherJobStart;
  logic motionDone, motionFault, stall, failMove, abortOtherJobs;
  logic [5:0] firstEntryNumber, lastEntryNumber;
  logic [4:0] tableWriteAddr;
  entry_s tableWriteData;
  seq_status_s status;
  motion_cmd_s motionCmd;
  motion_cmd_s lastCmd;
  int mismatches = 0;
  int nChecks = 0;
  int nCmd, nAbort;
  motion_sequence_runner motion_sequence_runner_inst (.clock(clock), .reset_n(reset_n),
    .start(start), .firstEntryNumber(firstEntryNumber), .lastEntryNumber(lastEntryNumber),
    .tableWrite(tableWrite), .tableWriteAddr(tableWriteAddr), .tableWriteData(tableWriteData),
    .axisEnabled(axisEnabled), .otherJobStart(otherJobStart), .motionDone(motionDone),
    .motionFault(motionFault), .status(status), .motionCmd(motionCmd),
    .abortOtherJobs(abortOtherJobs));
  axis_model axis_model_inst (.clock(clock), .motionCmd(motionCmd), .stall(stall),
    .failMove(failMove), .motionDone(motionDone), .motionFault(motionFault));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (motionCmd.valid === 1'b1) begin
      nCmd++;
      lastCmd = motionCmd;
    end
    if (abortOtherJobs === 1'b1) nAbort++;
  end
  task finalReport;
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task check(input logic [63:0] seen, input logic [63:0] exp);
    nChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task put(input int a, input cmd_kind_e k, input logic [31:0] v);
    @(negedge clock);
    tableWrite = 1'b1;
    tableWriteAddr = 5'(a - 1);
    tableWriteData = '{k, 16'(16'h0100 + a), v, 32'h10};
    @(negedge clock);
    tableWrite = 1'b0;
  endtask
  // a stalled axis gets the job interrupted by another motion job
  task run(input logic [5:0] f, input logic [5:0] l);
    int i;
    @(negedge clock);
    nCmd = 0;
    nAbort = 0;
    firstEntryNumber = f;
    lastEntryNumber = l;
    start = 1'b1;
    repeat (6) @(negedge clock);
    start = 1'b0;
    otherJobStart = stall;
    @(negedge clock);
    otherJobStart = 1'b0;
    for (i = 0; i < 300 && status.busy !== 1'b0; i++) @(negedge clock);
    if (i == 300) begin
      mismatches++;
      finalReport();
    end
  endtask
  task errchk(input logic [15:0] id, input logic [15:0] info);
    check({status.error, status.busy, status.done}, 3'h4);
    check({status.faultId, status.faultInfo}, {id, info});
  endtask
  initial begin
    reset_n = 1'b0;
    {start, tableWrite, otherJobStart, stall, failMove} = '0;
    firstEntryNumber = `SEQ_FIRST_DEFAULT;
    lastEntryNumber = `SEQ_LAST_DEFAULT;
    tableWriteAddr = '0;
    tableWriteData = '0;
    axisEnabled = 1'b1;
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
    check(status, 64'h0);
    put(1, CMD_EMPTY, 32'h0);
    put(2, CMD_REL, 32'h64);
    put(3, CMD_WAIT, 32'h3);
    put(4, CMD_VEL, 32'h0);
    put(5, CMD_HALT, 32'h0);
    put(6, CMD_SEP, 32'h0);
    put(7, CMD_HALT, 32'h0);
    put(8, CMD_ABS, 32'h32);
    put(9, CMD_BAD, 32'h0);
    run(1, 5);
    check({status.error, status.busy, status.done}, 3'h1);
    check({nCmd, nAbort}, {32'h3, 32'h1});
    check({status.step, status.code}, {6'h05, 16'h0105});
    check({lastCmd.kind, lastCmd.value}, {CMD_HALT, 32'h0});
    run(6, 8);
    check({nCmd, nAbort}, {32'h1, 32'h1});
    check(status.step, 6'h08);
    check({lastCmd.kind, lastCmd.value}, {CMD_ABS, 32'h32});
    check(lastCmd.speed, 32'h10);
    run(1, 32);
    errchk(`SEQ_ERR_KIND, 16'h0009);
    run(0, 5);
    errchk(`SEQ_ERR_RANGE, 16'h0000);
    run(3, 2);
    errchk(`SEQ_ERR_RANGE, 16'h0003);
    run(1, 33);
    errchk(`SEQ_ERR_RANGE, 16'h0001);
    axisEnabled = 1'b0;
    run(1, 5);
    errchk(`SEQ_ERR_AXIS, 16'h0000);
    axisEnabled = 1'b1;
    failMove = 1'b1;
    run(2, 2);
    errchk(`SEQ_ERR_MOTION, 16'h0002);
    check({lastCmd.kind, lastCmd.value}, {CMD_REL, 32'h64});
    failMove = 1'b0;
    stall = 1'b1;
    run(2, 2);
    check({status.aborted, status.busy, status.done, status.error}, 4'h8);
    stall = 1'b0;
    reset_n = 1'b0;
    @(negedge clock);
    check(status, 64'h0);
    check({motionCmd.valid, abortOtherJobs}, 2'h0);
    reset_n = 1'b1;
    run(2, 2);
    check({status.error, status.busy, status.done}, 3'h1);
    check({nCmd, nAbort}, {32'h1, 32'h1});
    finalReport();
  end
endmodule
